/* dv/core_model.sv */
/*
 * Model of the core's interrupt side: vectoring and return pulses.
 * Assumes one core clock; the bench calls pulse() or pop_pair() for each event.
 */
`timescale 1ns/1ps
module core_model
    import page_stack_pkg::*;
(
    input  wire logic clk,
    output logic      int_entry,
    output byte_t     int_page,
    output logic      int_return
);
    initial begin
        int_entry  = 1'b0;
        int_return = 1'b0;
        int_page   = 8'h5a;
    end

    // One-cycle event; page is only meaningful beside the entry pulse
    task automatic pulse(input logic e, input logic r, input byte_t p);
        @(posedge clk);
        int_entry  <= e;
        int_return <= r;
        int_page   <= p;
        @(posedge clk);
        int_entry  <= 1'b0;
        int_return <= 1'b0;
        int_page   <= ~p;
        @(negedge clk);
    endtask

    // Two returns in consecutive cycles: the stack pops twice
    task automatic pop_pair();
        @(posedge clk);
        int_return <= 1'b1;
        repeat (2) @(posedge clk);
        int_return <= 1'b0;
        @(negedge clk);
    endtask
endmodule // core_model

/* dv/tb_peripheral_page_stack.sv */
/*
 * Self-checking bench for the page stack: register port tasks and
 * interrupt events from the core model, compared with expected pages.
 * Assumes the package constants and the one-cycle read latency.
 */
`timescale 1ns/1ps
module tb_peripheral_page_stack
    import page_stack_pkg::*;
;

    logic       clk;
    logic       arst_n;
    byte_t      dir_addr;
    byte_t      dir_wdata;
    logic       dir_wr;
    logic       dir_rd;
    logic       dir_direct;
    logic       dir_bit;
    byte_t      dir_rdata;
    logic       sfr_sel;
    logic       ram_sel;
    logic       bit_ok;
    logic       int_entry;
    byte_t      int_page;
    logic       int_return;
    byte_t      cur_page;
    logic       page_ok;
    logic       auto_en;
    byte_t      dec;
    int         num_errors;
    int         compares;
    byte_t      da [5] = '{8'h80, 8'h7f, 8'hff, 8'h88, 8'h85};
    logic       dd [5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
    byte_t      de [5] = '{8'h05, 8'h02, 8'h04, 8'h05, 8'h02};

    peripheral_page_stack peripheral_page_stack_inst (
        .CLK(clk), .ARST_N(arst_n), .DIR_ADDR(dir_addr),
        .DIR_WDATA(dir_wdata), .DIR_WR(dir_wr), .DIR_RD(dir_rd),
        .DIR_DIRECT(dir_direct), .DIR_BIT(dir_bit),
        .DIR_RDATA(dir_rdata), .SFR_SEL(sfr_sel), .RAM_SEL(ram_sel),
        .BIT_OK(bit_ok), .INT_ENTRY(int_entry), .INT_PAGE(int_page),
        .INT_RETURN(int_return), .CUR_PAGE(cur_page),
        .PAGE_OK(page_ok), .AUTO_EN(auto_en)
    );

    core_model core_model_inst (
        .clk(clk), .int_entry(int_entry), .int_page(int_page),
        .int_return(int_return)
    );

    // ------------------------------------------------------------------
    // Clock, verdict and watchdog
    // ------------------------------------------------------------------
    always #50 clk = ~clk;

    task automatic stop_test();
        if (num_errors == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        stop_test();
    end

    // ------------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------------
    task automatic cmp(input byte_t got, input byte_t exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask

    // One strobe cycle; decode outputs captured while it is high
    task automatic drive(input logic w, input byte_t a, input byte_t d,
                         input logic dir, input logic bm);
        @(posedge clk);
        dir_wr     <= w;
        dir_rd     <= ~w;
        dir_addr   <= a;
        dir_wdata  <= d;
        dir_direct <= dir;
        dir_bit    <= bm;
        @(negedge clk);
        dec = {5'h00, sfr_sel, ram_sel, bit_ok};
        @(posedge clk);
        dir_wr    <= 1'b0;
        dir_rd    <= 1'b0;
        dir_addr  <= ~a;
        dir_wdata <= ~d;
        @(negedge clk);
    endtask

    task automatic wr(input byte_t a, input byte_t d);
        drive(1'b1, a, d, 1'b1, 1'b0);
    endtask

    task automatic rd(input byte_t a, input byte_t exp);
        drive(1'b0, a, 8'h00, 1'b1, 1'b0);
        cmp(dir_rdata, exp);
    endtask

    task automatic stk(input byte_t t, input byte_t m, input byte_t b);
        cmp(cur_page, t);
        rd(ADDR_STACK_MID, m);
        rd(ADDR_STACK_BOT, b);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0; arst_n = 1'b0; dir_addr = 8'h00; dir_wdata = 8'h00;
        dir_wr = 1'b0; dir_rd = 1'b0; dir_direct = 1'b0; dir_bit = 1'b0;
        num_errors = 0; compares = 0;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        stk(8'h00, 8'h00, 8'h00);
        cmp({7'h00, auto_en}, 8'h01);
        rd(ADDR_PAGE_CTRL, 8'h00);
        wr(ADDR_PAGE_SEL, 8'h0f);
        cmp(cur_page, 8'h0f);
        cmp({7'h00, page_ok}, 8'h01);
        wr(ADDR_PAGE_CTRL, 8'hff);
        rd(ADDR_PAGE_CTRL, 8'h01);
        wr(ADDR_PAGE_SEL, 8'h05);
        cmp({7'h00, page_ok}, 8'h00);
        rd(ADDR_PAGE_SEL, 8'h05);
        wr(ADDR_STACK_MID, 8'h33);
        wr(ADDR_STACK_BOT, 8'h44);
        stk(8'h05, 8'h33, 8'h44);
        drive(1'b1, ADDR_PAGE_SEL, 8'h77, 1'b1, 1'b1);
        cmp(cur_page, 8'h05);
        drive(1'b1, ADDR_STACK_MID, 8'h99, 1'b0, 1'b0);
        rd(ADDR_STACK_MID, 8'h33);
        for (int i = 0; i < 5; i++) begin
            drive(1'b0, da[i], 8'h00, dd[i], 1'b0);
            cmp(dec, de[i]);
        end
        wr(ADDR_PAGE_SEL, 8'h0f);
        core_model_inst.pulse(1'b1, 1'b0, PAGE_BASE);
        stk(8'h00, 8'h0f, 8'h33);
        wr(ADDR_PAGE_SEL, 8'h05);
        stk(8'h05, 8'h0f, 8'h33);
        core_model_inst.pulse(1'b1, 1'b0, PAGE_BASE);
        stk(8'h00, 8'h05, 8'h0f);
        core_model_inst.pulse(1'b0, 1'b1, 8'h00);
        stk(8'h05, 8'h0f, 8'h00);
        wr(ADDR_STACK_MID, 8'h5a);
        wr(ADDR_STACK_BOT, 8'h0f);
        core_model_inst.pulse(1'b0, 1'b1, 8'h00);
        stk(8'h5a, 8'h0f, 8'h00);
        core_model_inst.pulse(1'b1, 1'b1, PAGE_BASE);
        stk(8'h00, 8'h5a, 8'h0f);
        core_model_inst.pulse(1'b0, 1'b1, 8'h00);
        stk(8'h5a, 8'h0f, 8'h00);
        wr(ADDR_PAGE_SEL, 8'h0f);
        wr(ADDR_PAGE_CTRL, 8'h00);
        cmp({7'h00, auto_en}, 8'h00);
        core_model_inst.pulse(1'b1, 1'b0, PAGE_BASE);
        cmp(cur_page, 8'h0f);
        core_model_inst.pulse(1'b0, 1'b1, 8'h00);
        stk(8'h0f, 8'h0f, 8'h00);
        @(posedge clk);
        arst_n <= 1'b0;
        @(negedge clk);
        cmp(cur_page, 8'h00);
        cmp({7'h00, auto_en}, 8'h01);
        @(posedge clk);
        arst_n <= 1'b1;
        stk(8'h00, 8'h00, 8'h00);
        wr(ADDR_PAGE_SEL, 8'h0f);
        wr(ADDR_STACK_MID, 8'h22);
        // Push and a bottom write in the same cycle: the push wins
        fork
            core_model_inst.pulse(1'b1, 1'b0, PAGE_BASE);
            wr(ADDR_STACK_BOT, 8'h66);
        join
        stk(8'h00, 8'h0f, 8'h22);
        core_model_inst.pop_pair();
        stk(8'h22, 8'h00, 8'h00);
        stop_test();
    end
endmodule // tb_peripheral_page_stack

/* hdl/page_ctrl_reg.sv */
/*
 * Page control register: holds the auto-paging enable.
 * Assumes the write strobe is already qualified by address and page.
 */
`timescale 1ns/1ps
module page_ctrl_reg
    import page_stack_pkg::*;
(
    input  wire logic   clk,
    input  wire logic   arst_n,
    input  wire logic   wr_en,
    input  wire byte_t  wdata,
    output byte_t       rdata,
    output logic        auto_en
);

    logic auto_en_reg;

    // --------------------------------------------------------------
    // Enable bit
    // --------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            auto_en_reg <= AUTO_EN_RESET;
        end else if (wr_en) begin
            auto_en_reg <= wdata[AUTO_EN_BIT];
        end
    end

    assign auto_en = auto_en_reg;

    always_comb begin
        rdata              = ZERO_BYTE;
        rdata[AUTO_EN_BIT] = auto_en_reg;
    end

endmodule // page_ctrl_reg

/* hdl/page_stack_pkg.sv */
/*
 * Constants, types and helper functions shared by the special register
 * page stack and its address decoder.
 * Assumes an 8-bit direct address space and one core clock.
 */
package page_stack_pkg;

    typedef logic [7:0] byte_t;

    // ------------------------------------------------------------------
    // Address space
    // ------------------------------------------------------------------
    localparam byte_t       SFR_LOW        = 8'h80;
    localparam byte_t       SFR_HIGH       = 8'hff;
    localparam int unsigned NIB_MSB        = 3;
    localparam logic [3:0]  BIT_NIB_A      = 4'h0;
    localparam logic [3:0]  BIT_NIB_B      = 4'h8;

    // ------------------------------------------------------------------
    // Pages
    // ------------------------------------------------------------------
    localparam byte_t       PAGE_BASE      = 8'h00;
    localparam byte_t       PAGE_ALT       = 8'h0f;
    localparam byte_t       EMPTY_PAGE     = 8'h00;
    localparam byte_t       PAGE_RESET     = 8'h00;
    localparam byte_t       ZERO_BYTE      = 8'h00;

    // ------------------------------------------------------------------
    // Register offsets and fields
    // ------------------------------------------------------------------
    localparam byte_t       ADDR_PAGE_CTRL = 8'h84;
    localparam byte_t       ADDR_STACK_MID = 8'h85;
    localparam byte_t       ADDR_STACK_BOT = 8'h86;
    localparam byte_t       ADDR_PAGE_SEL  = 8'ha7;
    localparam byte_t       PAGE_CTRL_HOME = PAGE_ALT;
    localparam int unsigned AUTO_EN_BIT    = 0;
    localparam logic        AUTO_EN_RESET  = 1'b1;

    typedef struct packed {
        byte_t top;
        byte_t middle;
        byte_t bottom;
    } page_stack_s;

    typedef struct packed {
        logic sfr_sel;
        logic ram_sel;
        logic bit_ok;
        logic page_ok;
    } space_s;

    typedef enum logic [1:0] {
        OP_NONE = 2'b00,
        OP_PUSH = 2'b01,
        OP_POP  = 2'b10
    } stack_op_e;

    function automatic logic in_sfr_space(input byte_t a);
        return (a >= SFR_LOW) && (a <= SFR_HIGH);
    endfunction

    function automatic logic bit_addressable(input byte_t a);
        return in_sfr_space(a) &&
               ((a[NIB_MSB:0] == BIT_NIB_A) || (a[NIB_MSB:0] == BIT_NIB_B));
    endfunction

    function automatic logic page_exists(input byte_t p);
        return (p == PAGE_BASE) || (p == PAGE_ALT);
    endfunction

    // A register answers on its home page, or anywhere if all-pages
    function automatic logic reg_reached(input byte_t a, input byte_t target,
                                         input byte_t page, input byte_t home,
                                         input logic all_pages);
        return (a == target) && (all_pages || (page == home));
    endfunction

endpackage

/* hdl/peripheral_page_stack.sv */
/*
 * Special register page select with a three-entry page stack that
 * follows interrupt entry and return, plus its own register port.
 * Assumes the core gives one-cycle entry and return pulses and a
 * direct-access port whose read data is taken one cycle later.
 */
`timescale 1ns/1ps
module peripheral_page_stack
    import page_stack_pkg::*;
(
    input  wire logic   CLK,
    input  wire logic   ARST_N,
    input  wire byte_t  DIR_ADDR,
    input  wire byte_t  DIR_WDATA,
    input  wire logic   DIR_WR,
    input  wire logic   DIR_RD,
    input  wire logic   DIR_DIRECT,
    input  wire logic   DIR_BIT,
    output byte_t       DIR_RDATA,
    output logic        SFR_SEL,
    output logic        RAM_SEL,
    output logic        BIT_OK,
    input  wire logic   INT_ENTRY,
    input  wire byte_t  INT_PAGE,
    input  wire logic   INT_RETURN,
    output byte_t       CUR_PAGE,
    output logic        PAGE_OK,
    output logic        AUTO_EN
);

    // --------------------------------------------------------------
    // Declarations
    // --------------------------------------------------------------
    page_stack_s stack_reg;
    page_stack_s stack_next;
    stack_op_e   op;
    space_s      space;
    byte_t       ctrl_rdata;
    byte_t       read_value;
    byte_t       rdata_reg;
    logic        auto_en;
    logic        byte_wr;
    logic        byte_rd;
    logic        hit_ctrl;
    logic        hit_sel;
    logic        hit_mid;
    logic        hit_bot;
    logic        wr_ctrl;
    logic        wr_sel;
    logic        wr_mid;
    logic        wr_bot;

    // --------------------------------------------------------------
    // Address decode
    // --------------------------------------------------------------
    sfr_space_decode sfr_space_decode_inst (
        .addr   (DIR_ADDR),
        .page   (stack_reg.top),
        .access (DIR_WR || DIR_RD),
        .direct (DIR_DIRECT),
        .space  (space)
    );

    assign SFR_SEL = space.sfr_sel;
    assign RAM_SEL = space.ram_sel;
    assign BIT_OK  = space.bit_ok;
    assign PAGE_OK = space.page_ok;

    // Own registers are byte-only, so bit-mode accesses are ignored
    assign byte_wr = DIR_WR && space.sfr_sel && !DIR_BIT;
    assign byte_rd = DIR_RD && space.sfr_sel && !DIR_BIT;

    assign hit_ctrl = reg_reached(DIR_ADDR, ADDR_PAGE_CTRL,
                                  stack_reg.top, PAGE_CTRL_HOME, 1'b0);
    assign hit_sel  = reg_reached(DIR_ADDR, ADDR_PAGE_SEL,
                                  stack_reg.top, PAGE_BASE, 1'b1);
    assign hit_mid  = reg_reached(DIR_ADDR, ADDR_STACK_MID,
                                  stack_reg.top, PAGE_BASE, 1'b1);
    assign hit_bot  = reg_reached(DIR_ADDR, ADDR_STACK_BOT,
                                  stack_reg.top, PAGE_BASE, 1'b1);

    assign wr_ctrl = byte_wr && hit_ctrl;
    assign wr_sel  = byte_wr && hit_sel;
    assign wr_mid  = byte_wr && hit_mid;
    assign wr_bot  = byte_wr && hit_bot;

    // --------------------------------------------------------------
    // Page control
    // --------------------------------------------------------------
    page_ctrl_reg page_ctrl_reg_inst (
        .clk     (CLK),
        .arst_n  (ARST_N),
        .wr_en   (wr_ctrl),
        .wdata   (DIR_WDATA),
        .rdata   (ctrl_rdata),
        .auto_en (auto_en)
    );

    assign AUTO_EN = auto_en;

    // --------------------------------------------------------------
    // Stack operation select
    // --------------------------------------------------------------
    // Entry takes priority over a return in the same cycle
    always_comb begin
        if (!auto_en) begin
            op = OP_NONE;
        end else if (INT_ENTRY) begin
            op = OP_PUSH;
        end else if (INT_RETURN) begin
            op = OP_POP;
        end else begin
            op = OP_NONE;
        end
    end

    // --------------------------------------------------------------
    // Stack next state
    // --------------------------------------------------------------
    // Hardware push or pop wins over a software write in the same cycle
    always_comb begin
        stack_next = stack_reg;
        unique case (op)
            OP_PUSH: begin
                stack_next.bottom = stack_reg.middle;
                stack_next.middle = stack_reg.top;
                stack_next.top    = INT_PAGE;
            end
            OP_POP: begin
                stack_next.top    = stack_reg.middle;
                stack_next.middle = stack_reg.bottom;
                stack_next.bottom = EMPTY_PAGE;
            end
            OP_NONE: begin
                if (wr_sel) begin
                    stack_next.top = DIR_WDATA;
                end
                if (wr_mid) begin
                    stack_next.middle = DIR_WDATA;
                end
                if (wr_bot) begin
                    stack_next.bottom = DIR_WDATA;
                end
            end
            default: begin
                stack_next = stack_reg;
            end
        endcase
    end

    // --------------------------------------------------------------
    // Stack storage
    // --------------------------------------------------------------
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            stack_reg.top    <= PAGE_RESET;
            stack_reg.middle <= PAGE_RESET;
            stack_reg.bottom <= EMPTY_PAGE;
        end else begin
            stack_reg <= stack_next;
        end
    end

    assign CUR_PAGE = stack_reg.top;

    // --------------------------------------------------------------
    // Read path
    // --------------------------------------------------------------
    // Unmapped or unimplemented locations read as zero
    always_comb begin
        read_value = ZERO_BYTE;
        if (hit_sel) begin
            read_value = stack_reg.top;
        end else if (hit_mid) begin
            read_value = stack_reg.middle;
        end else if (hit_bot) begin
            read_value = stack_reg.bottom;
        end else if (hit_ctrl) begin
            read_value = ctrl_rdata;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rdata_reg <= ZERO_BYTE;
        end else if (byte_rd) begin
            rdata_reg <= read_value;
        end else begin
            rdata_reg <= ZERO_BYTE;
        end
    end

    assign DIR_RDATA = rdata_reg;

    // --------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------
    sequence push_s;
        auto_en && INT_ENTRY;
    endsequence

    sequence pop_s;
        auto_en && INT_RETURN && !INT_ENTRY;
    endsequence

    sequence quiet_s;
        !INT_ENTRY && !INT_RETURN && !byte_wr;
    endsequence

    sequence read_s(logic hit);
        byte_rd && hit;
    endsequence

    push_top_a: assert property (@(posedge CLK) disable iff (!ARST_N)
        push_s |=> (stack_reg.top == $past(INT_PAGE)))
        else $error("top not loaded with interrupt page on entry");

    push_shift_a: assert property (@(posedge CLK) disable iff (!ARST_N)
        push_s |=> (stack_reg.middle == $past(stack_reg.top)) &&
                   (stack_reg.bottom == $past(stack_reg.middle)))
        else $error("push did not shift the stack down");

    push_bottom_a: assert property (@(posedge CLK) disable iff (!ARST_N)
        (push_s and (wr_bot && 1'b1))
            |=> (stack_reg.bottom == $past(stack_reg.middle)))
        else $error("software bottom write survived a push");

    pop_shift_a: assert property (@(posedge CLK) disable iff (!ARST_N)
        pop_s |=> (stack_reg.top == $past(stack_reg.middle)) &&
                  (stack_reg.middle == $past(stack_reg.bottom)))
        else $error("pop did not shift the stack up");

    pop_empty_a: assert property (@(posedge CLK) disable iff (!ARST_N)
        pop_s ##1 pop_s |=> (stack_reg.top == $past(stack_reg.bottom, 2)) &&
                            (stack_reg.middle == EMPTY_PAGE))
        else $error("empty bottom did not pop as page zero");

    auto_off_a: assert property (@(posedge CLK) disable iff (!ARST_N)
        (!auto_en && !byte_wr) |=> $stable(stack_reg))
        else $error("stack moved while auto-paging disabled");

    sw_no_push_a: assert property (@(posedge CLK) disable iff (!ARST_N)
        (wr_mid && !INT_ENTRY && !INT_RETURN)
            |=> (stack_reg.middle == $past(DIR_WDATA)) &&
                (stack_reg.top == $past(stack_reg.top)) &&
                (stack_reg.bottom == $past(stack_reg.bottom)))
        else $error("middle write disturbed other stack entries");

    sel_write_a: assert property (@(posedge CLK) disable iff (!ARST_N)
        (wr_sel && !INT_ENTRY && !INT_RETURN)
            |=> (CUR_PAGE == $past(DIR_WDATA)) &&
                (stack_reg.middle == $past(stack_reg.middle)))
        else $error("page select write did not change top only");

    ctrl_read_a: assert property (@(posedge CLK) disable iff (!ARST_N)
        read_s(hit_ctrl) |=> (DIR_RDATA[7:1] == 7'h00) &&
                             (DIR_RDATA[0] == auto_en))
        else $error("page control read value wrong");

    sel_read_a: assert property (@(posedge CLK) disable iff (!ARST_N)
        (read_s(hit_sel) and quiet_s) |=> (DIR_RDATA == CUR_PAGE))
        else $error("page select read does not match current page");

    route_a: assert property (@(posedge CLK) disable iff (!ARST_N)
        (DIR_DIRECT && DIR_ADDR[7] && (DIR_WR || DIR_RD))
            |-> (SFR_SEL && !RAM_SEL))
        else $error("upper direct access not routed to registers");

    rd_once_a: assert property (@(posedge CLK) disable iff (!ARST_N)
        !byte_rd |=> (DIR_RDATA == ZERO_BYTE))
        else $error("read data held beyond its cycle");

endmodule // peripheral_page_stack

/* hdl/sfr_space_decode.sv */
/*
 * Routes a data access to the special register space or to data RAM
 * and reports whether bit access and the selected page are valid.
 * Assumes the core flags direct addressing and bit-mode accesses.
 */
`timescale 1ns/1ps
module sfr_space_decode
    import page_stack_pkg::*;
(
    input  wire byte_t  addr,
    input  wire byte_t  page,
    input  wire logic   access,
    input  wire logic   direct,
    output space_s      space
);

    // --------------------------------------------------------------
    // Routing
    // --------------------------------------------------------------
    always_comb begin
        space.sfr_sel = access && direct && in_sfr_space(addr);
        space.ram_sel = access && !space.sfr_sel;
        space.bit_ok  = bit_addressable(addr);
        space.page_ok = page_exists(page);
    end

endmodule // sfr_space_decode
